// *** logic/adc_framed_serial_port.sv ***
// How it works
// - results leave on data out during reads; serial writes fill the control register
// - pending conversion starts and hold wait until the settling pulse ends
// - settling pulse rises on write frame fall, times out from sixth falling clock
// - every control write restarts the settling pulse
// - mode pin low makes us master driving serial clock and read frame sync
// - master: conversion end pulls read frame low and enables clock and data
// - frame is a zero, three channel bits, twelve result bits MSB first
// - output bits change on rising clock, stable at the next falling edge
// - master holds read frame low sixteen clocks, ends it on sixteenth rise
// - master: write frame low starts our serial clock for the write
// - only the first five written bits are kept, later bits ignored
// - control write takes effect after six serial clocks
// - mode pin high makes us slave with clock and read frame as inputs
// - slave: zero driven at frame fall if clock high, else at next rise
// - slave: data released on first rising clock or rising read frame after read
// - a result finished during a read is loaded after the frame ends
// - the soft convert bit in a write starts a conversion after settling
// - hardware start holds the track/hold on the start input's rising edge
// - conversion lasts fourteen and a half master clocks before the output load
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module adc_framed_serial_port
    import adc_port_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_DEF,
    parameter int SOFT_CONVERT_BIT_CYCLES = SOFT_CONVERT_BIT_CYCLES_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [AXI_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic serial_mode_select_i,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    input wire logic read_frame_sync_n_i,
    output logic read_frame_sync_n_o,
    output logic read_frame_sync_n_oe_o,
    input wire logic write_frame_sync_n_i,
    input wire logic data_in_i,
    output logic data_out_o,
    output logic data_out_oe_o,
    input wire logic hw_convert_start_n_i,
    output logic settle_delay_cap_pin_o,
    output logic track_hold_o,
    output logic [CH_W-1:0] channel_select_o
);
    pins_t raw, sy, prev_r;
    logic [$bits(pins_t)-1:0] sy_bits;
    logic master, sclk_r, sclk_oe_r, run, m_tick, sclk_rise, sclk_fall;
    logic [15:0] div_r;
    logic [2:0] wr_cnt_r;
    logic [CTRL_W-1:0] ctrl_sh_r, ctrl_r;
    logic ld6, wfs_fall, settle_act_r, timing_r;
    logic [15:0] settle_cnt_r, settle_cfg_r;
    logic hw_start, soft_start, pend_r, go, busy_r, hold_r, done, load_pend_r, load;
    logic [15:0] soft_convert_bit_cnt_r;
    logic [RESULT_W-1:0] sample_r, held_r;
    frame_t out_r;
    logic rd_act_r, rd_busy, wait_r, dout_r, doe_r, rfs_o_r, rfs_oe_r;
    logic [FRAME_W-1:0] sh_r;
    logic [4:0] rd_cnt_r;
    logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [AXI_AW-1:0] awa_r;
    logic [31:0] wd_r, rdata_r;
    logic [3:0] ws_r;
    logic wr_fire;

    function automatic logic mapped(input logic [AXI_AW-1:0] a);
        mapped = (a == REG_CTRL) || (a == REG_SAMPLE) || (a == REG_SETTLE) ||
                 (a == REG_STATUS) || (a == REG_RESULT);
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction : merge

    // pin inputs cross into the core clock domain
    assign raw.serial_mode_select = serial_mode_select_i;
    assign raw.sclk = sclk_i;
    assign raw.rfs_n = read_frame_sync_n_i;
    assign raw.wfs_n = write_frame_sync_n_i;
    assign raw.din = data_in_i;
    assign raw.hw_convert_start_n_n = hw_convert_start_n_i;
    pin_sync #(.W($bits(pins_t)), .RST_VAL(PINS_IDLE)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .d_i(raw),
        .q_o(sy_bits)
    );
    assign sy = pins_t'(sy_bits);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_r <= PINS_IDLE;
        end else begin
            prev_r <= sy;
        end
    end

    assign master = !sy.serial_mode_select;

    // master serial clock: idles high so the first edge of a frame is a fall
    assign run = master && (rd_act_r || !sy.wfs_n);
    assign m_tick = run && (div_r == 16'(SCLK_HALF - 1));
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r <= 16'h0000;
            sclk_r <= 1'b1;
            sclk_oe_r <= 1'b0;
        end else begin
            sclk_oe_r <= master;
            if (!run) begin
                div_r <= 16'h0000;
                sclk_r <= 1'b1;
            end else if (m_tick) begin
                div_r <= 16'h0000;
                sclk_r <= !sclk_r;
            end else begin
                div_r <= div_r + 16'h0001;
            end
        end
    end
    assign sclk_rise = master ? (m_tick && !sclk_r) : (sy.sclk && !prev_r.sclk);
    assign sclk_fall = master ? (m_tick && sclk_r) : (!sy.sclk && prev_r.sclk);

    // control write: five bits shifted, loaded on the sixth falling edge
    assign wfs_fall = !sy.wfs_n && prev_r.wfs_n;
    assign ld6 = sclk_fall && !sy.wfs_n && (wr_cnt_r == LOAD_EDGE_IDX);
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_cnt_r <= 3'h0;
            ctrl_sh_r <= '0;
            ctrl_r <= '0;
        end else if (wfs_fall) begin
            wr_cnt_r <= 3'h0;
        end else if (sclk_fall && !sy.wfs_n && (wr_cnt_r <= LOAD_EDGE_IDX)) begin
            wr_cnt_r <= wr_cnt_r + 3'h1;
            if (wr_cnt_r < DATA_EDGES) begin
                ctrl_sh_r <= {ctrl_sh_r[CTRL_W-2:0], sy.din};
            end
            if (ld6) begin
                ctrl_r <= ctrl_sh_r;
            end
        end
    end

    // settling pulse; a fresh write frame always restarts it
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            settle_act_r <= 1'b0;
            timing_r <= 1'b0;
            settle_cnt_r <= 16'h0000;
        end else if (wfs_fall) begin
            settle_act_r <= 1'b1;
            timing_r <= 1'b0;
        end else if (ld6) begin
            timing_r <= 1'b1;
            settle_cnt_r <= settle_cfg_r;
        end else if (timing_r) begin
            if (settle_cnt_r == 16'h0000) begin
                settle_act_r <= 1'b0;
                timing_r <= 1'b0;
            end else begin
                settle_cnt_r <= settle_cnt_r - 16'h0001;
            end
        end
    end

    // conversion: starts queue while settling or converting, a running conversion is never cut short by a new start
    assign hw_start = sy.hw_convert_start_n_n && !prev_r.hw_convert_start_n_n;
    assign soft_start = ld6 && ctrl_sh_r[CTRL_SOFT_CONVERT_BIT_POS];
    assign go = pend_r && !settle_act_r && !busy_r;
    assign done = busy_r && (soft_convert_bit_cnt_r == 16'(SOFT_CONVERT_BIT_CYCLES - 1));
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
            busy_r <= 1'b0;
            hold_r <= 1'b0;
            soft_convert_bit_cnt_r <= 16'h0000;
            held_r <= '0;
        end else begin
            pend_r <= hw_start || soft_start || (pend_r && !go);
            if (go) begin
                busy_r <= 1'b1;
                hold_r <= 1'b1;
                soft_convert_bit_cnt_r <= 16'h0000;
                held_r <= sample_r;
            end else if (done) begin
                busy_r <= 1'b0;
                hold_r <= 1'b0;
            end else if (busy_r) begin
                soft_convert_bit_cnt_r <= soft_convert_bit_cnt_r + 16'h0001;
            end
        end
    end

    // output register load is deferred while a read frame is open
    assign rd_busy = master ? rd_act_r : !sy.rfs_n;
    assign load = load_pend_r && !rd_busy;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            load_pend_r <= 1'b0;
            out_r <= '0;
        end else begin
            load_pend_r <= done || (load_pend_r && !load);
            if (load) begin
                out_r <= '{lead: 1'b0, ch: ctrl_r[CTRL_CH_MSB:CTRL_CH_LSB],
                           result: held_r};
            end
        end
    end

    // read frame shifter, shared by both modes
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_act_r <= 1'b0;
            wait_r <= 1'b0;
            sh_r <= '0;
            rd_cnt_r <= 5'h00;
            dout_r <= 1'b0;
            doe_r <= 1'b0;
            rfs_o_r <= 1'b1;
            rfs_oe_r <= 1'b0;
        end else begin
            rfs_oe_r <= master;
            if (master && load) begin
                rd_act_r <= 1'b1;
                rfs_o_r <= 1'b0;
                doe_r <= 1'b1;
                wait_r <= 1'b0;
                sh_r <= FRAME_W'({1'b0, ctrl_r[CTRL_CH_MSB:CTRL_CH_LSB], held_r});
                dout_r <= 1'b0;
                rd_cnt_r <= 5'h00;
            end else if (!master && !sy.rfs_n && prev_r.rfs_n) begin
                rd_act_r <= 1'b1;
                sh_r <= out_r;
                dout_r <= 1'b0;
                rd_cnt_r <= 5'h00;
                doe_r <= sy.sclk;
                wait_r <= !sy.sclk;
            end else if (!master && sy.rfs_n && !prev_r.rfs_n) begin
                rd_act_r <= 1'b0;
                doe_r <= 1'b0;
                wait_r <= 1'b0;
            end else if (rd_act_r && sclk_rise) begin
                if (wait_r) begin
                    wait_r <= 1'b0;
                    doe_r <= 1'b1;
                end else if (rd_cnt_r == LAST_SHIFT) begin
                    rd_act_r <= 1'b0;
                    doe_r <= 1'b0;
                    rfs_o_r <= 1'b1;
                end else begin
                    sh_r <= {sh_r[FRAME_W-2:0], 1'b0};
                    dout_r <= sh_r[FRAME_W-2];
                    rd_cnt_r <= rd_cnt_r + 5'h01;
                end
            end else if (!master && !rd_act_r) begin
                doe_r <= 1'b0;
            end
        end
    end

    // bus write side: address and data taken in either order
    assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awa_r <= '0;
            wd_r <= 32'h0000_0000;
            ws_r <= 4'h0;
        end else begin
            if (awready_r && s_axi_awvalid_i) begin
                aw_got_r <= 1'b1;
                awa_r <= s_axi_awaddr_i;
                awready_r <= 1'b0;
            end
            if (wready_r && s_axi_wvalid_i) begin
                w_got_r <= 1'b1;
                wd_r <= s_axi_wdata_i;
                ws_r <= s_axi_wstrb_i;
                wready_r <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= mapped(awa_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // writable registers: sample value fed to the converter, settling count
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_r <= '0;
            settle_cfg_r <= SETTLE_RST;
        end else if (wr_fire && awa_r == REG_SAMPLE) begin
            sample_r <= RESULT_W'(merge(32'(sample_r), wd_r, ws_r));
        end else if (wr_fire && awa_r == REG_SETTLE) begin
            settle_cfg_r <= 16'(merge(32'(settle_cfg_r), wd_r, ws_r));
        end
    end

    // bus read side; status bits are a live view of the block
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (arready_r && s_axi_arvalid_i) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr_i)
                REG_CTRL: rdata_r <= 32'(ctrl_r);
                REG_SAMPLE: rdata_r <= 32'(sample_r);
                REG_SETTLE: rdata_r <= 32'(settle_cfg_r);
                REG_STATUS: rdata_r <= 32'({rd_act_r, load_pend_r, hold_r, busy_r,
                                            pend_r, settle_act_r, master});
                REG_RESULT: rdata_r <= 32'(out_r);
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o = wready_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;
    assign sclk_o = sclk_r;
    assign sclk_oe_o = sclk_oe_r;
    assign read_frame_sync_n_o = rfs_o_r;
    assign read_frame_sync_n_oe_o = rfs_oe_r;
    assign data_out_o = dout_r;
    assign data_out_oe_o = doe_r;
    assign settle_delay_cap_pin_o = settle_act_r;
    assign track_hold_o = hold_r;
    assign channel_select_o = ctrl_r[CTRL_CH_MSB:CTRL_CH_LSB];

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_settle_gate: assert property ($rose(busy_r) |-> !$past(settle_act_r))
        else $error("conversion began while settling");
    a_soft_convert_bit_length: assert property ($rose(busy_r) |-> ##SOFT_CONVERT_BIT_CYCLES $fell(busy_r))
        else $error("conversion length wrong");
    a_settle_rise: assert property (wfs_fall |=> settle_act_r && !timing_r)
        else $error("settling pulse not restarted");
    a_ctrl_load: assert property (ld6 |=> ctrl_r == $past(ctrl_sh_r) && timing_r)
        else $error("control load missed");
    a_master_lead: assert property (master && load |=> !rfs_o_r && doe_r && !dout_r)
        else $error("master frame start wrong");
    a_frame_end: assert property ($rose(rfs_o_r) |-> $past(rd_cnt_r) == LAST_SHIFT
                                  && !doe_r)
        else $error("frame ended at wrong count");
    a_defer_load: assert property (rd_busy |=> $stable(out_r))
        else $error("output loaded during read");
    a_slave_release: assert property (!master && sy.rfs_n && !prev_r.rfs_n |=> !doe_r)
        else $error("data not released");
    a_shift_rise: assert property (doe_r && $past(doe_r) && $changed(dout_r)
                                   |-> $past(sclk_rise))
        else $error("data changed off a rising edge");
    c_master_read: cover property (master && load ##[1:1000] $rose(rfs_o_r));
    c_slave_read: cover property (!master && $rose(rd_act_r) ##[1:1000] $fell(rd_act_r));
    c_soft_soft_convert_bit: cover property (soft_start ##[1:1000] $rose(busy_r));
    c_deferred: cover property (load_pend_r && rd_busy ##1 load);
endmodule : adc_framed_serial_port
`default_nettype wire

// *** common/adc_port_pkg.sv ***
`default_nettype none
package adc_port_pkg;
    // frame and control word layout
    localparam int CTRL_W = 5;
    localparam int CH_W = 3;
    localparam int RESULT_W = 12;
    localparam int FRAME_W = 16;
    localparam int CTRL_CH_MSB = 4;
    localparam int CTRL_CH_LSB = 2;
    localparam int CTRL_SOFT_CONVERT_BIT_POS = 1;
    localparam logic [2:0] LOAD_EDGE_IDX = 3'h5;
    localparam logic [2:0] DATA_EDGES = 3'h5;
    localparam logic [4:0] LAST_SHIFT = 5'h0F;
    // timing: core clock, master clock and conversion length
    localparam int CORE_CLK_HZ = 50_000_000;
    localparam int MCLK_DIV = 2;
    localparam int SOFT_CONVERT_BIT_HALF_MCLK = 29;
    localparam int SOFT_CONVERT_BIT_CYCLES_DEF = SOFT_CONVERT_BIT_HALF_MCLK * MCLK_DIV / 2;
    localparam int SCLK_HZ = 2_500_000;
    localparam int SCLK_HALF_DEF = CORE_CLK_HZ / (2 * SCLK_HZ);
    localparam int SETTLE_NS = 2000;
    localparam logic [15:0] SETTLE_RST = 16'(SETTLE_NS / (1_000_000_000 / CORE_CLK_HZ));
    // register map, byte addresses
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SAMPLE = 8'h04;
    localparam logic [7:0] REG_SETTLE = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RESULT = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // pins sampled from outside the core clock domain
    typedef struct packed {
        logic serial_mode_select;
        logic sclk;
        logic rfs_n;
        logic wfs_n;
        logic din;
        logic hw_convert_start_n_n;
    } pins_t;
    localparam pins_t PINS_IDLE = '{serial_mode_select: 1'b0, sclk: 1'b1, rfs_n: 1'b1, wfs_n: 1'b1,
                                    din: 1'b0, hw_convert_start_n_n: 1'b1};

    typedef struct packed {
        logic lead;
        logic [CH_W-1:0] ch;
        logic [RESULT_W-1:0] result;
    } frame_t;
endpackage : adc_port_pkg
`default_nettype wire

// *** logic/pin_sync.sv ***
`default_nettype none
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output var logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // three stages; a bit only moves once stages two and three agree
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    q_o[i] <= s3_r[i];
                end
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

// *** test/host_serial_model.sv ***
`default_nettype none
module host_serial_model (
    input wire logic slave_i,
    input wire logic sclk_pin_i,
    input wire logic rfs_pin_n_i,
    input wire logic dout_pin_i,
    output logic sclk_o,
    output logic rfs_n_o,
    output logic wfs_n_o,
    output logic din_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle levels; the link clock stands high between frames
    initial begin
        sclk_o <= 1'b1;
        rfs_n_o <= 1'b1;
        wfs_n_o <= 1'b1;
        din_o <= 1'b0;
    end
    // one 160 ns link clock period, falling edge first; non-blocking so no race with clk
    task automatic tick();
        #80 sclk_o <= 1'b0;
        #80 sclk_o <= 1'b1;
    endtask : tick
    // control write, msb first; a new bit goes out while the clock is high
    task automatic put(input logic [4:0] w, input int n);
        wfs_n_o <= 1'b0;
        if (slave_i)
            #200;
        for (int i = 0; i < n; i++) begin
            din_o <= (i < 5) ? w[4-i] : ~din_o;
            if (slave_i)
                tick();
            else begin
                @(negedge sclk_pin_i);
                @(posedge sclk_pin_i);
            end
        end
        wfs_n_o <= 1'b1;
        din_o <= ~din_o;
    endtask : put
    // slave read ends by raising the read frame
    task automatic end_read();
        rfs_n_o <= 1'b1;
    endtask : end_read
    // result read; in slave mode sampled late in the low phase, since pin sync delays bits
    // lo starts the frame with the clock low, so the leading zero waits for one rise
    task automatic get(output logic [15:0] f, input logic lo);
        if (slave_i) begin
            sclk_o <= !lo;
            rfs_n_o <= 1'b0;
            #200;
            if (lo)
                #80 sclk_o <= 1'b1;
            for (int i = 0; i < 16; i++) begin
                #80 sclk_o <= 1'b0;
                #76 f[15-i] = dout_pin_i;
                #4 sclk_o <= 1'b1;
            end
        end else begin
            @(negedge rfs_pin_n_i);
            for (int i = 0; i < 16; i++) begin
                @(negedge sclk_pin_i);
                f[15-i] = dout_pin_i;
            end
        end
    endtask : get
endmodule : host_serial_model
`default_nettype wire

// *** test/adc_framed_serial_port_tb.sv ***
`default_nettype none
module adc_framed_serial_port_tb;
    import adc_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SOFT_CONVERT_BIT = 29;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
        logic [1:0] resp;
    } row_t;
    row_t tbl[8] = '{'{1'b1, REG_SAMPLE, 32'h0000_0ABC, RESP_OKAY},
        '{1'b0, REG_SAMPLE, 32'h0000_0ABC, RESP_OKAY}, '{1'b1, REG_SETTLE, 32'h0000_0028, RESP_OKAY},
        '{1'b0, REG_SETTLE, 32'h0000_0028, RESP_OKAY}, '{1'b1, 8'h20, 32'h0000_0001, RESP_SLVERR},
        '{1'b0, 8'h20, 32'h0000_0000, RESP_SLVERR}, '{1'b1, REG_CTRL, 32'h0000_001F, RESP_OKAY},
        '{1'b0, REG_CTRL, 32'h0000_0000, RESP_OKAY}};
    logic core_clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready, mode, hw_convert_start_n_n;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, q;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awrdy, wrdy, bvld, arrdy, rvld, sclk_d, sclk_oe, rfs_d, rfs_oe, dout, dout_oe;
    logic settle, hold, h_sclk, h_rfs_n, h_wfs_n, h_din;
    logic [2:0] chan;
    logic [15:0] f;
    int err_total = 0, n_compared = 0, cyc = 0, hold_n = 0;
    // pin levels seen by both sides; data out has a pull-up when released
    wire logic sclk_pin = sclk_oe ? sclk_d : h_sclk;
    wire logic rfs_pin = rfs_oe ? rfs_d : h_rfs_n;
    wire logic dout_pin = dout_oe ? dout : 1'b1;

    adc_framed_serial_port #(.SCLK_HALF(10), .SOFT_CONVERT_BIT_CYCLES(SOFT_CONVERT_BIT)) dut (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvld), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arrdy), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvld), .s_axi_rready_i(rready),
        .serial_mode_select_i(mode), .sclk_i(sclk_pin), .sclk_o(sclk_d), .sclk_oe_o(sclk_oe),
        .read_frame_sync_n_i(rfs_pin), .read_frame_sync_n_o(rfs_d),
        .read_frame_sync_n_oe_o(rfs_oe), .write_frame_sync_n_i(h_wfs_n), .data_in_i(h_din),
        .data_out_o(dout), .data_out_oe_o(dout_oe), .hw_convert_start_n_i(hw_convert_start_n_n),
        .settle_delay_cap_pin_o(settle), .track_hold_o(hold), .channel_select_o(chan));

    host_serial_model host (.slave_i(mode), .sclk_pin_i(sclk_pin), .rfs_pin_n_i(rfs_pin),
        .dout_pin_i(dout_pin), .sclk_o(h_sclk), .rfs_n_o(h_rfs_n), .wfs_n_o(h_wfs_n),
        .din_o(h_din));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one bus transfer; valids drop at the edge their ready is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic [1:0] rr);
        @(posedge core_clk_i);
        if (w) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        do begin
            @(posedge core_clk_i);
            if (awrdy)
                awvalid <= 1'b0;
            if (wrdy)
                wvalid <= 1'b0;
            if (arrdy)
                arvalid <= 1'b0;
        end while ((w ? bvld : rvld) !== 1'b1);
        rq = rdata;
        rr = w ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
    endtask : bus
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    // hold never starts inside the settling pulse and lasts one conversion
    always @(posedge core_clk_i) begin
        if (hold === 1'b1)
            hold_n++;
        else if (hold_n != 0) begin
            chk("hold length", SOFT_CONVERT_BIT, 32'(hold_n));
            hold_n = 0;
        end
        if (hold === 1'b1 && hold_n == 1)
            chk("settle at hold", 32'h0, 32'(settle));
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        {rst_i, hw_convert_start_n_n, wstrb} = 6'h3F;
        {awvalid, wvalid, bready, arvalid, rready, mode} = 6'h00;
        {awaddr, araddr, wdata} = '0;
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        foreach (tbl[i]) begin
            bus(tbl[i].wr, tbl[i].a, tbl[i].d, q, r);
            chk("bus resp", 32'(tbl[i].resp), 32'(r));
            if (!tbl[i].wr)
                chk("read data", tbl[i].d, q);
        end
        // reset in mid-run brings the settling count back
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        bus(1'b0, REG_SETTLE, 32'h0, q, r);
        chk("settle reset", 32'h0000_0064, q);
        chk("channel reset", 32'h0, 32'(chan));
        chk("master drive", 32'h3, 32'({sclk_oe, rfs_oe}));
        bus(1'b1, REG_SAMPLE, 32'h0000_0ABC, q, r);
        repeat (8) @(posedge core_clk_i);
        // master: eight clocks, soft convert set, result frame follows by itself
        host.put(5'b10110, 8);
        chk("settle high", 32'h1, 32'(settle));
        chk("channel", 32'h5, 32'(chan));
        host.get(f, 1'b0);
        chk("master frame", 32'h5ABC, 32'(f));
        wait (rfs_d === 1'b1);
        @(posedge core_clk_i);
        chk("oe after frame", 32'h0, 32'(dout_oe));
        bus(1'b0, REG_RESULT, 32'h0, q, r);
        chk("result reg", 32'h5ABC, q);
        bus(1'b0, REG_CTRL, 32'h0, q, r);
        chk("control reg", 32'h16, q);
        // slave: six-clock write, hardware start well after settling
        mode <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        chk("slave drive", 32'h0, 32'({sclk_oe, rfs_oe}));
        host.put(5'b01100, 6);
        repeat (8) @(posedge core_clk_i);
        chk("channel", 32'h3, 32'(chan));
        repeat (150) @(posedge core_clk_i);
        hw_convert_start_n_n <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        hw_convert_start_n_n <= 1'b1;
        wait (hold === 1'b1);
        wait (hold === 1'b0);
        repeat (4) @(posedge core_clk_i);
        host.get(f, 1'b0);
        chk("slave frame", 32'h3ABC, 32'(f));
        repeat (10) @(posedge core_clk_i);
        chk("oe released", 32'h0, 32'(dout_oe));
        host.end_read();
        // second read opens with the clock low: leading zero waits for a rise
        repeat (10) @(posedge core_clk_i);
        host.get(f, 1'b1);
        chk("slave frame low", 32'h3ABC, 32'(f));
        host.end_read();
        repeat (10) @(posedge core_clk_i);
        chk("oe after frame rise", 32'h0, 32'(dout_oe));
        close_out();
    end
endmodule : adc_framed_serial_port_tb
`default_nettype wire
